// File: hw/dbs_params.svh
// constants of the dynamic bus sizing block
// Operation
// - memory cycles reach every address from all zeros to all ones.
// - programmed i/o cycles stay at or below the printed i/o limit.
// - coprocessor i/o cycles use addresses 800000f8 through 800000ff only.
// - lowest-addressed byte rides data bits 7:0, highest rides 31:24.
// - narrow port request is sampled afresh in every bus cycle.
// - with narrow port, wide or misaligned transfers split into a second cycle.
// - with narrow port, all operand bytes move over the lower data half.
// - narrow port request has no effect unless lane 2 or 3 is selected.
// - narrow upper-only read takes lanes 2 and 3 from the lower data half.
// - every upper-only write copies the upper data half onto the lower half.
// - narrow read of both halves runs two cycles, bytes 0-1 then 2-3.
// - narrow write of both halves drives all bytes, then copies bytes 2-3 low.
// - second cycle of a split keeps lane selects 0 and 1 negated.
// - only contiguous groups of lane selects are ever asserted.
`ifndef DBS_PARAMS_SVH
`define DBS_PARAMS_SVH
`define DBS_MEM_FIRST 32'h00000000
`define DBS_MEM_LAST 32'hffffffff
`define DBS_IO_PROG_LAST 32'h00000fff
`define DBS_COP_FIRST 32'h800000f8
`define DBS_COP_LAST 32'h800000ff
`define DBS_COP_OFS_MASK 32'h00000007
`define DBS_LANES_IDLE 4'hf
`define DBS_UPPER_LANES 4'hc
`define DBS_WORD_ADDR_RST 30'h3fffffff
`endif

// File: hw/dbs_pkg.sv
// types of the dynamic bus sizing block
`default_nettype none
package dbs_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_addr = 3'h1,
    st_data = 3'h2,
    st_resp = 3'h3
  } dbs_state_t;
endpackage
`default_nettype wire

// File: hw/dbs_lane_mux.sv
// write data steering onto the four byte lanes
`default_nettype none
module dbs_lane_mux (
  input wire logic [3:0] i_lanes,
  input wire logic i_second,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_bus_data
);
  always_comb begin
    o_bus_data = i_wdata;
    // upper-only and second-split writes also show bytes 2-3 low, so a narrow port needs nothing more
    if (i_second || (i_lanes[1:0] == 2'h0)) begin
      o_bus_data[15:0] = i_wdata[31:16];
    end
  end
endmodule
`default_nettype wire

// File: hw/dbs_top.sv
// dynamic bus sizing: one dword request to one or two bus cycles
`default_nettype none
`include "dbs_params.svh"
module dbs_top (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_req_valid,
  input wire logic [31:0] i_req_addr,
  input wire logic [3:0] i_req_lanes,
  input wire logic i_req_write,
  input wire logic i_req_io,
  input wire logic i_req_cop,
  input wire logic [31:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic o_rsp_err,
  output logic [31:0] o_rsp_rdata,
  output logic o_ads_n,
  output logic [29:0] o_word_address_bits,
  output logic [3:0] o_byte_lane_selects_n,
  output logic o_write,
  output logic o_mem_io,
  output logic [31:0] o_data_out,
  output logic o_data_oe_n,
  input wire logic [31:0] i_data_in,
  input wire logic i_ready_n,
  input wire logic i_narrow_port_request_n
);
  logic rst_meta_r;
  logic rstn_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_r <= 1'b0;
      rstn_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rstn_r <= rst_meta_r;
    end
  end

  dbs_pkg::dbs_state_t state_r, state_nxt;
  logic second_r, second_nxt;
  logic ads_n_r, ads_n_nxt;
  logic [29:0] word_r, word_nxt;
  logic [3:0] lanes_r, lanes_nxt;
  // pin copy of the lanes, so the active-low selects leave straight from a flop
  logic [3:0] lanes_n_r, lanes_n_nxt;
  logic write_r, write_nxt;
  logic mem_r, mem_nxt;
  logic cop_r, cop_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [31:0] dout_r, dout_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [31:0] acc_r, acc_nxt;
  logic rsp_r, rsp_nxt;
  logic err_r, err_nxt;
  logic rdy_r, rdy_nxt;
  logic [31:0] first_data;
  logic [31:0] second_data;
  logic [31:0] eff_addr;
  logic contig;
  logic addr_bad;
  logic narrow;
  logic upper_used;
  logic both_halves;

  // never lets a gap pattern or an empty pattern reach the lane pins
  always_comb begin
    case (i_req_lanes)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'hc, 4'he, 4'hf: contig = 1'b1;
      default: contig = 1'b0;
    endcase
  end

  always_comb begin
    eff_addr = i_req_addr;
    if (i_req_cop) begin
      eff_addr = `DBS_COP_FIRST | (i_req_addr & `DBS_COP_OFS_MASK);
    end
  end

  // programmed i/o beyond the limit is refused with no bus cycle at all
  assign addr_bad = i_req_io && !i_req_cop && (i_req_addr > `DBS_IO_PROG_LAST);

  dbs_lane_mux u_first_mux (
    .i_lanes(i_req_lanes),
    .i_second(1'b0),
    .i_wdata(i_req_wdata),
    .o_bus_data(first_data)
  );

  dbs_lane_mux u_second_mux (
    .i_lanes(lanes_r & `DBS_UPPER_LANES),
    .i_second(1'b1),
    .i_wdata(wdata_r),
    .o_bus_data(second_data)
  );

  assign narrow = !i_narrow_port_request_n;
  assign upper_used = (lanes_r[3:2] != 2'h0);
  assign both_halves = lanes_r[1] && lanes_r[2];

  always_comb begin
    state_nxt = state_r;
    second_nxt = second_r;
    ads_n_nxt = 1'b1;
    word_nxt = word_r;
    lanes_nxt = lanes_r;
    write_nxt = write_r;
    mem_nxt = mem_r;
    cop_nxt = cop_r;
    wdata_nxt = wdata_r;
    dout_nxt = dout_r;
    oe_n_nxt = oe_n_r;
    acc_nxt = acc_r;
    rsp_nxt = 1'b0;
    err_nxt = err_r;
    rdy_nxt = 1'b0;
    case (state_r)
      dbs_pkg::st_idle: begin
        rdy_nxt = 1'b1;
        if (i_req_valid) begin
          rdy_nxt = 1'b0;
          if (!contig || addr_bad) begin
            err_nxt = 1'b1;
            state_nxt = dbs_pkg::st_resp;
          end else begin
            err_nxt = 1'b0;
            second_nxt = 1'b0;
            ads_n_nxt = 1'b0;
            word_nxt = eff_addr[31:2];
            lanes_nxt = i_req_lanes;
            write_nxt = i_req_write;
            mem_nxt = !i_req_io && !i_req_cop;
            cop_nxt = i_req_cop;
            wdata_nxt = i_req_wdata;
            dout_nxt = first_data;
            oe_n_nxt = !i_req_write;
            acc_nxt = 32'h00000000;
            state_nxt = dbs_pkg::st_addr;
          end
        end
      end
      dbs_pkg::st_addr: begin
        state_nxt = dbs_pkg::st_data;
      end
      dbs_pkg::st_data: begin
        if (!i_ready_n) begin
          if (narrow && upper_used && both_halves && !second_r) begin
            // unselected low bytes stay zero
            for (int i = 0; i < 2; i++) begin
              if (lanes_r[i]) begin
                acc_nxt[8*i +: 8] = i_data_in[8*i +: 8];
              end
            end
            second_nxt = 1'b1;
            ads_n_nxt = 1'b0;
            lanes_nxt = lanes_r & `DBS_UPPER_LANES;
            dout_nxt = second_data;
            state_nxt = dbs_pkg::st_addr;
          end else begin
            for (int i = 0; i < 4; i++) begin
              if (lanes_r[i]) begin
                acc_nxt[8*i +: 8] = i_data_in[8*i +: 8];
              end
            end
            if (narrow && upper_used) begin
              // the upper data half is ignored, lanes 2-3 come from the lower half
              if (lanes_r[2]) begin
                acc_nxt[23:16] = i_data_in[7:0];
              end
              if (lanes_r[3]) begin
                acc_nxt[31:24] = i_data_in[15:8];
              end
            end
            lanes_nxt = ~`DBS_LANES_IDLE;
            oe_n_nxt = 1'b1;
            state_nxt = dbs_pkg::st_resp;
          end
        end
      end
      dbs_pkg::st_resp: begin
        rsp_nxt = 1'b1;
        rdy_nxt = 1'b1;
        state_nxt = dbs_pkg::st_idle;
      end
      default: begin
        state_nxt = dbs_pkg::st_idle;
      end
    endcase
    lanes_n_nxt = ~lanes_nxt;
  end

  always_ff @(posedge i_clk or negedge rstn_r) begin
    if (!rstn_r) begin
      state_r <= dbs_pkg::st_idle;
      second_r <= 1'b0;
      ads_n_r <= 1'b1;
      word_r <= `DBS_WORD_ADDR_RST;
      lanes_r <= ~`DBS_LANES_IDLE;
      lanes_n_r <= `DBS_LANES_IDLE;
      write_r <= 1'b0;
      mem_r <= 1'b0;
      cop_r <= 1'b0;
      wdata_r <= 32'h00000000;
      dout_r <= 32'h00000000;
      oe_n_r <= 1'b1;
      acc_r <= 32'h00000000;
      rsp_r <= 1'b0;
      err_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      second_r <= second_nxt;
      ads_n_r <= ads_n_nxt;
      word_r <= word_nxt;
      lanes_r <= lanes_nxt;
      lanes_n_r <= lanes_n_nxt;
      write_r <= write_nxt;
      mem_r <= mem_nxt;
      cop_r <= cop_nxt;
      wdata_r <= wdata_nxt;
      dout_r <= dout_nxt;
      oe_n_r <= oe_n_nxt;
      acc_r <= acc_nxt;
      rsp_r <= rsp_nxt;
      err_r <= err_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign o_req_ready = rdy_r;
  assign o_rsp_valid = rsp_r;
  assign o_rsp_err = err_r;
  assign o_rsp_rdata = acc_r;
  assign o_ads_n = ads_n_r;
  assign o_word_address_bits = word_r;
  assign o_byte_lane_selects_n = lanes_n_r;
  assign o_write = write_r;
  assign o_mem_io = mem_r;
  assign o_data_out = dout_r;
  assign o_data_oe_n = oe_n_r;

  default clocking dbs_cb @(posedge i_clk);
  endclocking
  default disable iff (!rstn_r);

  logic [31:0] bus_addr;
  always_comb begin
    bus_addr = {word_r, 2'h0};
    if (!lanes_r[0]) begin
      bus_addr = {word_r, 2'h1};
      if (!lanes_r[1]) begin
        bus_addr = {word_r, 2'h2};
        if (!lanes_r[2]) begin
          bus_addr = {word_r, 2'h3};
        end
      end
    end
  end

  lanes_contig_a: assert property (!ads_n_r |-> lanes_r inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7,
    4'h8, 4'hc, 4'he, 4'hf}) else $error("lane selects not contiguous");
  second_lanes_a: assert property (second_r && state_r != dbs_pkg::st_idle && state_r != dbs_pkg::st_resp
    |-> lanes_r[1:0] == 2'h0) else $error("low lanes asserted in second cycle");
  upper_dup_a: assert property (!oe_n_r && (lanes_r[1:0] == 2'h0) && state_r == dbs_pkg::st_data
    |-> o_data_out[15:0] == o_data_out[31:16]) else $error("upper write not copied low");
  io_limit_a: assert property (!ads_n_r && !mem_r && !cop_r |-> bus_addr <= `DBS_IO_PROG_LAST)
    else $error("programmed io beyond limit");
  cop_range_a: assert property (!ads_n_r && cop_r
    |-> bus_addr >= `DBS_COP_FIRST && bus_addr <= `DBS_COP_LAST) else $error("coprocessor address out of range");
  split_start_a: assert property (state_r == dbs_pkg::st_data && !i_ready_n && narrow && !second_r
    && lanes_r[1] && lanes_r[2] |=> !ads_n_r && second_r && $stable(word_r) && $stable(write_r) && $stable(mem_r))
    else $error("second cycle not started correctly");
  narrow_ignore_a: assert property (state_r == dbs_pkg::st_data && !i_ready_n && lanes_r[3:2] == 2'h0
    |=> state_r == dbs_pkg::st_resp ##1 o_rsp_valid) else $error("lower-only cycle was split");
  upper_read_a: assert property (state_r == dbs_pkg::st_data && !i_ready_n && narrow && oe_n_r
    && lanes_r == `DBS_UPPER_LANES |=> acc_r[31:16] == $past(i_data_in[15:0]))
    else $error("narrow upper read not taken low");
  wide_read_a: assert property (state_r == dbs_pkg::st_data && !i_ready_n && !narrow && lanes_r == 4'hf
    && !second_r |=> acc_r == $past(i_data_in)) else $error("wide read lanes misplaced");
  no_ads_wait_a: assert property (!ads_n_r |=> ads_n_r && state_r == dbs_pkg::st_data)
    else $error("address strobe not one cycle");
  first_write_a: assert property (!ads_n_r && !second_r && !oe_n_r && lanes_r[1:0] != 2'h0
    |-> o_data_out == wdata_r) else $error("first write cycle lacks bytes");
  second_write_a: assert property (!ads_n_r && second_r && !oe_n_r
    |-> o_data_out[15:0] == wdata_r[31:16]) else $error("second write bytes not copied low");
  idle_lanes_a: assert property (state_r == dbs_pkg::st_idle
    |-> o_byte_lane_selects_n == `DBS_LANES_IDLE) else $error("lane selects asserted while idle");

  split_read_c: cover property (!ads_n_r && second_r && !write_r);
  split_write_c: cover property (!ads_n_r && second_r && write_r);
  upper_only_c: cover property (state_r == dbs_pkg::st_data && !i_ready_n && narrow && lanes_r[1:0] == 2'h0);
  err_c: cover property (o_rsp_valid && o_rsp_err);
  wide_read_c: cover property (state_r == dbs_pkg::st_data && !i_ready_n && !narrow && !write_r);
endmodule
`default_nettype wire

// File: verification/dbs_port_model.sv
// behavioural 32- and 16-bit ports with their decoder
`default_nettype none
module dbs_port_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ads_n,
  input wire logic [29:0] i_word_address_bits,
  input wire logic [3:0] i_byte_lane_selects_n,
  input wire logic i_mem_io,
  output logic o_ready_n,
  output logic o_narrow_port_request_n,
  output logic [31:0] o_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy;
  int wait_cnt;
  int cyc;
  logic [31:0] pt;
  initial begin
    busy = 0;
    wait_cnt = 0;
    cyc = 0;
    o_ready_n = 1;
    o_narrow_port_request_n = 1;
    o_data_in = 32'h0;
    forever begin
      @(posedge i_clk);
      #1;
      cyc++;
      o_ready_n = 1;
      o_narrow_port_request_n = 1;
      // released bus never shows a stale value
      o_data_in = ~o_data_in;
      if (!i_rstn) busy = 0;
      else if (busy && wait_cnt > 0) wait_cnt--;
      else if (busy) begin
        busy = 0;
        pt = {i_word_address_bits[15:0] ^ 16'h5a5a, i_word_address_bits[17:2]};
        o_ready_n = 0;
        o_narrow_port_request_n = !(i_mem_io && i_word_address_bits[10]);
        // half word bit from lanes; upper half is junk on a narrow port
        if (!o_narrow_port_request_n)
          o_data_in = {~pt[31:16], (&i_byte_lane_selects_n[1:0]) ? pt[31:16] : pt[15:0]};
        else o_data_in = pt;
      end else if (!i_ads_n) begin
        busy = 1;
        wait_cnt = cyc % 3;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/dbs_top_tb.sv
// self-checking bench for the bus sizing block
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module dbs_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [29:0] a; logic [3:0] ln; logic [2:0] dir; logic [31:0] d; logic [31:0] k;} dbs_bus_t;
  typedef struct packed {logic e; logic c; logic [31:0] r;} dbs_rsp_t;
  logic i_clk = 0;
  logic i_rstn = 0;
  logic i_req_valid = 0, i_req_write = 0, i_req_io = 0, i_req_cop = 0;
  logic [31:0] i_req_addr = 0, i_req_wdata = 0, o_rsp_rdata, o_data_out, i_data_in, rnd;
  logic [3:0] i_req_lanes = 0, o_byte_lane_selects_n;
  logic o_req_ready, o_rsp_valid, o_rsp_err, o_ads_n, o_write, o_mem_io, o_data_oe_n;
  logic i_ready_n, i_narrow_port_request_n;
  logic [29:0] o_word_address_bits;
  dbs_bus_t bq[$];
  dbs_rsp_t rq[$];
  dbs_bus_t mb;
  dbs_rsp_t mr;
  int error_cnt = 0, num_checks = 0, cyc_cnt = 0;
  integer seed = 88400;
  dbs_top u_dbs_top (.i_clk, .i_rstn, .i_req_valid, .i_req_addr, .i_req_lanes, .i_req_write, .i_req_io,
    .i_req_cop, .i_req_wdata, .o_req_ready, .o_rsp_valid, .o_rsp_err, .o_rsp_rdata, .o_ads_n,
    .o_word_address_bits, .o_byte_lane_selects_n, .o_write, .o_mem_io, .o_data_out, .o_data_oe_n,
    .i_data_in, .i_ready_n, .i_narrow_port_request_n);
  dbs_port_model u_dbs_port_model (.i_clk, .i_rstn, .i_ads_n(o_ads_n), .i_word_address_bits(o_word_address_bits),
    .i_byte_lane_selects_n(o_byte_lane_selects_n), .i_mem_io(o_mem_io), .o_ready_n(i_ready_n),
    .o_narrow_port_request_n(i_narrow_port_request_n), .o_data_in(i_data_in));
  always #5 i_clk = ~i_clk;
  function automatic logic [31:0] bm(input logic [3:0] l);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  task automatic finish_test();
    `CHK("queues_empty", 0, bq.size() + rq.size())
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic req(input logic [31:0] a, input logic [3:0] l, input logic wr, io, cp, input logic [31:0] wd);
    logic [31:0] fa, pt, k;
    logic [15:0] okl;
    logic err, up, both;
    int n;
    okl = 16'hd1de;
    fa = cp ? (32'h800000f8 | {29'h0, a[2:0]}) : a;
    pt = {fa[17:2] ^ 16'h5a5a, fa[19:4]};
    err = !okl[l] || (io && !cp && a > 32'h00000fff);
    up = (l[1:0] == 2'h0);
    both = !io && !cp && a[12] && !up && (l[3:2] != 2'h0);
    k = wr ? bm(l) : 32'h0;
    if (up) k[15:0] = k[31:16];
    if (!err) bq.push_back('{fa[31:2], ~l, {wr, !(io || cp), !wr}, up ? {2{wd[31:16]}} : wd, k});
    if (!err && both)
      bq.push_back('{fa[31:2], ~(l & 4'hc), {wr, 1'b1, !wr}, {2{wd[31:16]}}, {2{k[31:16]}}});
    rq.push_back('{err, !err && !wr, pt & bm(l)});
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (o_req_ready !== 1'b1 && n < 50);
    {i_req_valid, i_req_addr, i_req_lanes, i_req_write, i_req_io, i_req_cop, i_req_wdata} = {1'b1, a, l, wr, io, cp, wd};
    @(posedge i_clk);
    #1;
    i_req_valid = 0;
  endtask
  always @(posedge i_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  always @(posedge i_clk) begin
    if (i_rstn && i_ready_n === 1'b0 && bq.size() > 0) begin
      mb = bq.pop_front();
      `CHK("bus_addr", mb.a, o_word_address_bits)
      `CHK("bus_lanes", mb.ln, o_byte_lane_selects_n)
      `CHK("bus_kind", mb.dir, {o_write, o_mem_io, o_data_oe_n})
      `CHK("bus_data", mb.d & mb.k, o_data_out & mb.k)
    end else if (i_ready_n === 1'b0) `CHK("bus_extra", 1'b0, 1'b1)
    if (o_rsp_valid === 1'b1 && rq.size() == 0) `CHK("rsp_extra", 1'b0, 1'b1)
    else if (o_rsp_valid === 1'b1) begin
      mr = rq.pop_front();
      `CHK("rsp_err", mr.e, o_rsp_err)
      if (mr.c) `CHK("rsp_rdata", mr.r, o_rsp_rdata)
    end
  end
  initial begin
    repeat (2) @(posedge i_clk);
    #1;
    `CHK("rst_bus", {1'b1, 4'hf, 30'h3fffffff, 1'b0}, {o_ads_n, o_byte_lane_selects_n, o_word_address_bits, o_req_ready})
    i_rstn = 1;
    $display("test reset done");
    // every lane pattern, both directions, wide and narrow port
    for (int i = 0; i < 64; i++) begin
      rnd = $random(seed);
      req({rnd[31:13], i[0], rnd[11:0]}, i[5:2], i[1], 1'b0, 1'b0, $random(seed));
    end
    req(32'h0, 4'hf, 1'b1, 1'b0, 1'b0, rnd);
    req(32'hffffffff, 4'h8, 1'b0, 1'b0, 1'b0, rnd);
    $display("test lanes done");
    // io around its top limit, then coprocessor cycles
    for (int i = 0; i < 16; i++)
      req(i[3] ? {29'h0, i[2:0]} : 32'h00000ffd + i[2:0], 4'hf >> i[1:0], i[0], !i[3], i[3], $random(seed));
    $display("test io done");
    for (int i = 0; i < 150; i++) begin
      rnd = $random(seed);
      req(rnd[4] ? {19'h0, rnd[12:0]} : $random(seed), rnd[3:0], rnd[5], rnd[4], rnd[6] & ~rnd[4], $random(seed));
    end
    $display("test random done");
    repeat (10) @(posedge i_clk);
    finish_test();
  end
endmodule
`default_nettype wire
